// >>> inc/vnsg_core_if.sv
/*
 * Carrier between the gating top and its virtual NMI and SMM lock units.
 * Assumes all three sit on the same clock and reset.
 */
`timescale 1ns/1ps
`default_nettype none
interface vnsg_core_if;
	logic load;
	logic ld_pend;
	logic ld_blk;
	logic inject;
	logic deliver;
	logic vec_done;
	logic iret_ok;
	logic exit_ev;
	logic virt_nmi_feature_pend;
	logic virt_nmi_feature_blk;
	logic virt_nmi_feature_busy;
	logic wr_hw;
	logic wr_smm;
	logic [31:0] wdata;
	logic lock;
	logic [31:0] smm_control_reg;
	logic gp;
	modport top (output load, ld_pend, ld_blk, inject, deliver, vec_done, iret_ok, exit_ev, wr_hw, wr_smm, wdata,
		input virt_nmi_feature_pend, virt_nmi_feature_blk, virt_nmi_feature_busy, lock, smm_control_reg, gp);
	modport virt_nmi_feature (input load, ld_pend, ld_blk, inject, deliver, vec_done, iret_ok, exit_ev,
		output virt_nmi_feature_pend, virt_nmi_feature_blk, virt_nmi_feature_busy);
	modport smm (input wr_hw, wr_smm, wdata, output lock, smm_control_reg, gp);
endinterface : vnsg_core_if
`default_nettype wire

// >>> inc/vnsg_defines.svh
/*
 * Register offsets, field positions, reset values and event codes of the NMI and SMI gating block.
 * Assumes the APB address is eight bits wide and every register takes one aligned word.
 */
`ifndef VNSG_DEFINES_SVH
`define VNSG_DEFINES_SVH

`define VNSG_ADDR_CTRL 8'h00
`define VNSG_ADDR_VM_CONTROL_BLOCK 8'h04
`define VNSG_ADDR_STAT 8'h08
`define VNSG_ADDR_SMMCTL 8'h0C
`define VNSG_ADDR_HWCFG 8'h10
`define VNSG_ADDR_CMD 8'h14
`define VNSG_ADDR_WBACK 8'h18
`define VNSG_ADDR_EXIT 8'h1C

`define VNSG_CTRL_GIF 0
`define VNSG_CTRL_VIRT_GLOBAL_INT_FLAG 1
`define VNSG_CTRL_NMI_ICPT 2
`define VNSG_CTRL_SMI_ICPT 3

`define VNSG_VM_CONTROL_BLOCK_PEND 11
`define VNSG_VM_CONTROL_BLOCK_BLK 12
`define VNSG_VM_CONTROL_BLOCK_ON 26

`define VNSG_CMD_ENTRY 0
`define VNSG_CMD_INJ_NMI 1
`define VNSG_CMD_SET_GLOBAL_INT_INSTR 2
`define VNSG_CMD_CLGI 3

`define VNSG_HWCFG_LOCK 0

`define VNSG_STAT_VPEND 0
`define VNSG_STAT_VBLK 1
`define VNSG_STAT_VBUSY 2
`define VNSG_STAT_NMI_PEND 3
`define VNSG_STAT_SMI_PEND 4
`define VNSG_STAT_SYSTEM_MGMT_MEMORY 5
`define VNSG_STAT_GUEST 6
`define VNSG_STAT_SMM 7
`define VNSG_STAT_FEATURE 8

`define VNSG_FEATURE_VIRT_NMI_FEATURE 1'h1
`define VNSG_RST_WORD 32'h0000_0000
`define VNSG_RST_CODE 8'h00

`define VNSG_EXIT_NMI 8'h01
`define VNSG_EXIT_SMI 8'h02
`define VNSG_EXIT_OTHER 8'h03
`define VNSG_EXIT_INVALID 8'hFF

`endif

// >>> inc/vnsg_pkg.sv
/*
 * Types shared by the NMI and SMI gating block: the mode enum and the state records.
 * Assumes the defines header gives all offsets and codes.
 */
package vnsg_pkg;
	typedef enum logic [2:0] {
		VNSG_HOST = 3'h1,
		VNSG_GUEST = 3'h2,
		VNSG_SMM = 3'h4
	} vnsg_mode_e;

	typedef struct packed {
		vnsg_mode_e mode;
		logic global_int_flag;
		logic virt_global_int_flag;
		logic nmi_icpt;
		logic smi_icpt;
		logic [31:0] vm_control_block;
		logic nmi_pend;
		logic smi_pend;
		logic smi_io;
		logic from_guest;
		logic system_mgmt_memory;
		logic [7:0] code;
		logic [31:0] wback;
		logic exit_info;
		logic nmi_taken;
		logic smi_taken;
		logic virt_nmi_feature_taken;
		logic guest_exit;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} vnsg_top_s;

	typedef struct packed {
		logic pend;
		logic blk;
		logic busy;
	} vnsg_virt_nmi_feature_s;

	typedef struct packed {
		logic lock;
		logic [31:0] smm_control_reg;
		logic gp;
	} vnsg_smm_s;
endpackage : vnsg_pkg

// >>> src/vnsg_smm.sv
/*
 * SMM lock flag and SMM control register with the locked-write fault.
 * Assumes write strobes are one-cycle pulses from the APB slave.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vnsg_defines.svh"
module vnsg_smm import vnsg_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	vnsg_core_if.smm cif
);
	vnsg_smm_s s_q;
	vnsg_smm_s s_d;

	always_comb begin
		s_d = s_q;
		s_d.gp = 1'b0;
		if (cif.wr_hw && cif.wdata[`VNSG_HWCFG_LOCK]) begin
			s_d.lock = 1'b1;
		end
		if (cif.wr_smm) begin
			if (s_q.lock) begin
				s_d.gp = 1'b1;
			end else begin
				s_d.smm_control_reg = cif.wdata;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign cif.lock = s_q.lock;
	assign cif.smm_control_reg = s_q.smm_control_reg;
	assign cif.gp = s_q.gp;

	a_locked_write_faults: assert property (@(posedge pclk) disable iff (!presetn)
		cif.wr_smm && s_q.lock |=> s_q.gp && $stable(s_q.smm_control_reg))
		else $error("locked SMM control write did not fault");
endmodule : vnsg_smm
`default_nettype wire

// >>> src/vnsg_top.sv
/*
 * NMI and SMI gating with virtual NMI state, reached over an APB slave.
 * Assumes event inputs are synchronous one-cycle pulses except int_shadow, which is a level.
 */
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "vnsg_defines.svh"
module vnsg_top import vnsg_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic phys_nmi,
	input wire logic ext_smi,
	input wire logic ext_smi_io,
	input wire logic int_smi,
	input wire logic int_shadow,
	input wire logic iret_ok,
	input wire logic vec_done,
	input wire logic exit_req,
	input wire logic smm_return,
	output logic nmi_taken,
	output logic smi_taken,
	output logic virt_nmi_feature_taken,
	output logic guest_exit,
	output logic [7:0] exit_code,
	output logic exit_info_virt_nmi_feature,
	output logic [31:0] vm_control_block_wback,
	output logic in_guest,
	output logic system_mgmt_memory_mapped,
	output logic gp_fault
);
	vnsg_top_s s_q;
	vnsg_top_s s_d;
	vnsg_core_if cif ();

	logic wr;
	logic [31:0] cmd;
	logic guest;
	logic entry;
	logic entry_ok;
	logic deliver;
	logic exit_now;
	logic [7:0] code;
	logic virt_nmi_feature_ready;
	logic [31:0] stat;

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == `VNSG_ADDR_CTRL) || (a == `VNSG_ADDR_VM_CONTROL_BLOCK) || (a == `VNSG_ADDR_STAT) ||
			(a == `VNSG_ADDR_SMMCTL) || (a == `VNSG_ADDR_HWCFG) || (a == `VNSG_ADDR_CMD) ||
			(a == `VNSG_ADDR_WBACK) || (a == `VNSG_ADDR_EXIT);
	endfunction : addr_ok

	vnsg_virt_nmi_feature u_virt_nmi_feature (
		.pclk(pclk),
		.presetn(presetn),
		.cif(cif.virt_nmi_feature)
	);

	vnsg_smm u_smm (
		.pclk(pclk),
		.presetn(presetn),
		.cif(cif.smm)
	);

	always_comb begin
		stat = `VNSG_RST_WORD;
		stat[`VNSG_STAT_VPEND] = cif.virt_nmi_feature_pend;
		stat[`VNSG_STAT_VBLK] = cif.virt_nmi_feature_blk;
		stat[`VNSG_STAT_VBUSY] = cif.virt_nmi_feature_busy;
		stat[`VNSG_STAT_NMI_PEND] = s_q.nmi_pend;
		stat[`VNSG_STAT_SMI_PEND] = s_q.smi_pend;
		stat[`VNSG_STAT_SYSTEM_MGMT_MEMORY] = s_q.system_mgmt_memory;
		stat[`VNSG_STAT_GUEST] = s_q.mode == VNSG_GUEST;
		stat[`VNSG_STAT_SMM] = s_q.mode == VNSG_SMM;
		stat[`VNSG_STAT_FEATURE] = `VNSG_FEATURE_VIRT_NMI_FEATURE;
	end

	always_comb begin
		s_d = s_q;
		wr = psel && penable && s_q.pready && pwrite;
		cmd = (wr && paddr == `VNSG_ADDR_CMD) ? pwdata : `VNSG_RST_WORD;
		guest = s_q.mode == VNSG_GUEST;
		entry = (s_q.mode == VNSG_HOST) && cmd[`VNSG_CMD_ENTRY];
		entry_ok = !(s_q.vm_control_block[`VNSG_VM_CONTROL_BLOCK_ON] && !s_q.nmi_icpt);
		deliver = 1'b0;
		exit_now = 1'b0;
		code = `VNSG_RST_CODE;
		virt_nmi_feature_ready = guest && s_q.vm_control_block[`VNSG_VM_CONTROL_BLOCK_ON] && cif.virt_nmi_feature_pend && !cif.virt_nmi_feature_blk &&
			!cif.virt_nmi_feature_busy && s_q.global_int_flag && s_q.virt_global_int_flag && !int_shadow;
		s_d.nmi_taken = 1'b0;
		s_d.smi_taken = 1'b0;
		s_d.virt_nmi_feature_taken = 1'b0;
		s_d.guest_exit = 1'b0;

		// Setup phase answers in the next cycle with data and error prepared.
		s_d.pready = psel && !penable;
		s_d.pslverr = psel && !penable && !addr_ok(paddr);
		if (psel && !penable) begin
			unique case (paddr)
				`VNSG_ADDR_CTRL: s_d.prdata = {28'h0000000, s_q.smi_icpt, s_q.nmi_icpt, s_q.virt_global_int_flag, s_q.global_int_flag};
				`VNSG_ADDR_VM_CONTROL_BLOCK: s_d.prdata = s_q.vm_control_block;
				`VNSG_ADDR_STAT: s_d.prdata = stat;
				`VNSG_ADDR_SMMCTL: s_d.prdata = cif.smm_control_reg;
				`VNSG_ADDR_HWCFG: s_d.prdata = {31'h00000000, cif.lock};
				`VNSG_ADDR_WBACK: s_d.prdata = s_q.wback;
				`VNSG_ADDR_EXIT: s_d.prdata = {23'h000000, s_q.exit_info, s_q.code};
				default: s_d.prdata = `VNSG_RST_WORD;
			endcase
		end

		if (wr && paddr == `VNSG_ADDR_CTRL) begin
			s_d.global_int_flag = pwdata[`VNSG_CTRL_GIF];
			s_d.virt_global_int_flag = pwdata[`VNSG_CTRL_VIRT_GLOBAL_INT_FLAG];
			s_d.nmi_icpt = pwdata[`VNSG_CTRL_NMI_ICPT];
			s_d.smi_icpt = pwdata[`VNSG_CTRL_SMI_ICPT];
		end
		if (wr && paddr == `VNSG_ADDR_VM_CONTROL_BLOCK) begin
			s_d.vm_control_block = pwdata;
		end
		if (cmd[`VNSG_CMD_CLGI]) begin
			s_d.global_int_flag = 1'b0;
		end
		if (cmd[`VNSG_CMD_SET_GLOBAL_INT_INSTR]) begin
			s_d.global_int_flag = 1'b1;
		end

		// Each decision below uses the registered flags; only one event acts per cycle.
		if (s_q.mode == VNSG_SMM) begin
			if (smm_return) begin
				s_d.mode = s_q.from_guest ? VNSG_GUEST : VNSG_HOST;
				s_d.system_mgmt_memory = 1'b0;
			end
		end else if (entry) begin
			if (entry_ok) begin
				s_d.mode = VNSG_GUEST;
				s_d.global_int_flag = 1'b1;
			end else begin
				exit_now = 1'b1;
				code = `VNSG_EXIT_INVALID;
			end
		end else if (int_smi && s_q.global_int_flag) begin
			if (guest && s_q.smi_icpt) begin
				exit_now = 1'b1;
				code = `VNSG_EXIT_SMI;
			end else begin
				s_d.mode = VNSG_SMM;
				s_d.from_guest = guest;
				s_d.system_mgmt_memory = 1'b1;
				s_d.smi_taken = 1'b1;
			end
		end else if (s_q.smi_pend && s_q.global_int_flag) begin
			if (guest && s_q.smi_icpt) begin
				exit_now = 1'b1;
				code = `VNSG_EXIT_SMI;
			end else begin
				s_d.mode = VNSG_SMM;
				s_d.from_guest = guest;
				s_d.system_mgmt_memory = 1'b1;
				s_d.smi_taken = 1'b1;
				s_d.smi_pend = 1'b0;
				s_d.smi_io = 1'b0;
			end
		end else if (s_q.nmi_pend && s_q.global_int_flag) begin
			if (guest && s_q.nmi_icpt) begin
				exit_now = 1'b1;
				code = `VNSG_EXIT_NMI;
			end else if (!int_shadow) begin
				s_d.nmi_taken = 1'b1;
				s_d.nmi_pend = 1'b0;
			end
		end else if (guest && exit_req) begin
			exit_now = 1'b1;
			code = `VNSG_EXIT_OTHER;
		end else if (virt_nmi_feature_ready) begin
			deliver = 1'b1;
			s_d.virt_nmi_feature_taken = 1'b1;
		end

		// Arrivals set pending last so a take in the same cycle cannot lose them.
		if (phys_nmi) begin
			s_d.nmi_pend = 1'b1;
		end
		if (ext_smi || ext_smi_io) begin
			s_d.smi_pend = 1'b1;
		end
		if (ext_smi_io) begin
			s_d.smi_io = 1'b1;
		end

		if (exit_now) begin
			s_d.mode = VNSG_HOST;
			s_d.guest_exit = 1'b1;
			s_d.code = code;
			s_d.exit_info = cif.virt_nmi_feature_busy;
			s_d.wback = s_q.vm_control_block;
			if (guest && s_q.vm_control_block[`VNSG_VM_CONTROL_BLOCK_ON]) begin
				s_d.wback[`VNSG_VM_CONTROL_BLOCK_PEND] = cif.virt_nmi_feature_pend;
				s_d.wback[`VNSG_VM_CONTROL_BLOCK_BLK] = cif.virt_nmi_feature_blk && !cif.virt_nmi_feature_busy;
			end
			if (guest) begin
				s_d.global_int_flag = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{mode: VNSG_HOST, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign cif.load = entry && entry_ok && s_q.vm_control_block[`VNSG_VM_CONTROL_BLOCK_ON];
	assign cif.ld_pend = s_q.vm_control_block[`VNSG_VM_CONTROL_BLOCK_PEND];
	assign cif.ld_blk = s_q.vm_control_block[`VNSG_VM_CONTROL_BLOCK_BLK];
	assign cif.inject = cmd[`VNSG_CMD_INJ_NMI];
	assign cif.deliver = deliver;
	assign cif.vec_done = vec_done;
	assign cif.iret_ok = iret_ok && guest;
	assign cif.exit_ev = exit_now && guest;
	assign cif.wr_hw = wr && paddr == `VNSG_ADDR_HWCFG;
	assign cif.wr_smm = wr && paddr == `VNSG_ADDR_SMMCTL;
	assign cif.wdata = pwdata;

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign nmi_taken = s_q.nmi_taken;
	assign smi_taken = s_q.smi_taken;
	assign virt_nmi_feature_taken = s_q.virt_nmi_feature_taken;
	assign guest_exit = s_q.guest_exit;
	assign exit_code = s_q.code;
	assign exit_info_virt_nmi_feature = s_q.exit_info;
	assign vm_control_block_wback = s_q.wback;
	assign in_guest = s_q.mode[1];
	assign system_mgmt_memory_mapped = s_q.system_mgmt_memory;
	assign gp_fault = cif.gp;

	a_int_smi_dropped: assert property (@(posedge pclk) disable iff (!presetn)
		int_smi && !s_q.global_int_flag && !s_q.smi_pend && !ext_smi && !ext_smi_io |=> !s_q.smi_pend && !smi_taken)
		else $error("internal SMI with flag clear was not dropped");

	a_nmi_held_pending: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.nmi_pend && !s_q.global_int_flag |=> s_q.nmi_pend && !nmi_taken)
		else $error("NMI left pending state while flag clear");

	a_nmi_intercept_exit: assert property (@(posedge pclk) disable iff (!presetn)
		guest && s_q.global_int_flag && s_q.nmi_icpt && s_q.nmi_pend && !int_smi && !s_q.smi_pend
		|=> guest_exit && exit_code == `VNSG_EXIT_NMI && s_q.nmi_pend)
		else $error("intercepted NMI did not exit with NMI code and stay pending");

	a_entry_invalid: assert property (@(posedge pclk) disable iff (!presetn)
		entry && s_q.vm_control_block[`VNSG_VM_CONTROL_BLOCK_ON] && !s_q.nmi_icpt
		|=> guest_exit && exit_code == `VNSG_EXIT_INVALID && s_q.mode == VNSG_HOST)
		else $error("bad entry was not refused as invalid");

	a_virt_nmi_feature_gate: assert property (@(posedge pclk) disable iff (!presetn)
		virt_nmi_feature_taken |-> $past(s_q.global_int_flag) && $past(s_q.virt_global_int_flag) && !$past(int_shadow) && !$past(cif.virt_nmi_feature_blk))
		else $error("virtual NMI delivered while gated off");

	a_phys_first: assert property (@(posedge pclk) disable iff (!presetn)
		virt_nmi_feature_taken |-> !$past(s_q.nmi_pend))
		else $error("virtual NMI taken ahead of pending physical NMI");

	a_exit_in_delivery: assert property (@(posedge pclk) disable iff (!presetn)
		exit_now && guest && cif.virt_nmi_feature_busy && s_q.vm_control_block[`VNSG_VM_CONTROL_BLOCK_ON]
		|=> exit_info_virt_nmi_feature && !vm_control_block_wback[`VNSG_VM_CONTROL_BLOCK_BLK] ##1 !cif.virt_nmi_feature_blk)
		else $error("exit during delivery not recorded or blocked not zero");

	a_smi_enters_smm: assert property (@(posedge pclk) disable iff (!presetn)
		smi_taken |-> system_mgmt_memory_mapped && s_q.mode == VNSG_SMM)
		else $error("SMI taken without SMM entry and remap");

	a_int_smi_exit: assert property (@(posedge pclk) disable iff (!presetn)
		guest && s_q.global_int_flag && s_q.smi_icpt && int_smi && !s_q.smi_pend && !ext_smi && !ext_smi_io
		|=> guest_exit && exit_code == `VNSG_EXIT_SMI && !s_q.smi_pend)
		else $error("intercepted internal SMI did not exit unpended");

	a_ext_smi_exit: assert property (@(posedge pclk) disable iff (!presetn)
		guest && s_q.global_int_flag && s_q.smi_icpt && s_q.smi_pend && !int_smi
		|=> guest_exit && exit_code == `VNSG_EXIT_SMI && s_q.smi_pend)
		else $error("intercepted external SMI did not exit and stay pending");

	a_flag_takes_smi: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.mode == VNSG_HOST && !s_q.global_int_flag && s_q.smi_pend && cmd[`VNSG_CMD_SET_GLOBAL_INT_INSTR] && !cmd[`VNSG_CMD_ENTRY]
		|=> (entry or ##1 smi_taken))
		else $error("setting the flag did not take the pending SMI");

	a_smi_io_pending: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.smi_io |-> s_q.smi_pend)
		else $error("I/O SMI marker set without a pending SMI");

	a_smm_return_resumes: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.mode == VNSG_SMM && smm_return |=> !system_mgmt_memory_mapped && in_guest == $past(s_q.from_guest))
		else $error("SMM return did not unmap and resume the interrupted context");

	a_nmi_taken_host: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.mode == VNSG_HOST && s_q.global_int_flag && s_q.nmi_pend && !entry && !int_smi && !s_q.smi_pend &&
		!int_shadow && !phys_nmi |=> nmi_taken && !s_q.nmi_pend)
		else $error("NMI with flag set was not taken normally");

	a_shadow_blocks: assert property (@(posedge pclk) disable iff (!presetn)
		int_shadow |=> !nmi_taken && !virt_nmi_feature_taken)
		else $error("NMI recognised inside the interrupt shadow");

	a_entry_loads: assert property (@(posedge pclk) disable iff (!presetn)
		cif.load |=> cif.virt_nmi_feature_pend == $past(cif.ld_pend) &&
		cif.virt_nmi_feature_blk == ($past(cif.ld_blk) || $past(cif.inject)))
		else $error("entry did not load virtual pending and blocked");

	a_iret_unblocks: assert property (@(posedge pclk) disable iff (!presetn)
		cif.iret_ok && !deliver && !cif.exit_ev |=> !cif.virt_nmi_feature_blk)
		else $error("interrupt-return did not clear virtual blocked");

	a_exit_writeback: assert property (@(posedge pclk) disable iff (!presetn)
		exit_now && guest && s_q.vm_control_block[`VNSG_VM_CONTROL_BLOCK_ON] && !cif.virt_nmi_feature_busy
		|=> vm_control_block_wback[`VNSG_VM_CONTROL_BLOCK_PEND] == $past(cif.virt_nmi_feature_pend) &&
		vm_control_block_wback[`VNSG_VM_CONTROL_BLOCK_BLK] == $past(cif.virt_nmi_feature_blk))
		else $error("exit did not write back virtual pending and blocked");

	a_host_virt_nmi_feature_clear: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.mode == VNSG_HOST |-> !cif.virt_nmi_feature_pend && !cif.virt_nmi_feature_blk && !cif.virt_nmi_feature_busy)
		else $error("virtual NMI state left live in the host");
endmodule : vnsg_top
`default_nettype wire

// >>> src/vnsg_virt_nmi_feature.sv
/*
 * Guest virtual NMI pending, blocked and in-delivery state.
 * Assumes the top issues load, deliver and exit as mutually exclusive pulses.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vnsg_defines.svh"
module vnsg_virt_nmi_feature import vnsg_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	vnsg_core_if.virt_nmi_feature cif
);
	vnsg_virt_nmi_feature_s s_q;
	vnsg_virt_nmi_feature_s s_d;

	always_comb begin
		s_d = s_q;
		// Clears come first so that a delivery in the same cycle wins.
		if (cif.vec_done) begin
			s_d.busy = 1'b0;
		end
		if (cif.iret_ok) begin
			s_d.blk = 1'b0;
		end
		if (cif.load) begin
			s_d.pend = cif.ld_pend;
			s_d.blk = cif.ld_blk | cif.inject;
			s_d.busy = 1'b0;
		end
		if (cif.deliver) begin
			s_d.pend = 1'b0;
			s_d.blk = 1'b1;
			s_d.busy = 1'b1;
		end
		if (cif.exit_ev) begin
			s_d = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign cif.virt_nmi_feature_pend = s_q.pend;
	assign cif.virt_nmi_feature_blk = s_q.blk;
	assign cif.virt_nmi_feature_busy = s_q.busy;

	a_deliver_marks_state: assert property (@(posedge pclk) disable iff (!presetn)
		cif.deliver && !cif.exit_ev |=> !s_q.pend && s_q.blk && s_q.busy)
		else $error("virtual NMI delivery did not clear pending and set blocked");
endmodule : vnsg_virt_nmi_feature
`default_nettype wire

// >>> verif/vnsg_top_tb.sv
/*
 * Self-checking testbench of the NMI and SMI gating top, driven over APB and its event pins.
 * Assumes the design files, the package and the defines header are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vnsg_defines.svh"
module vnsg_top_tb import vnsg_pkg::*; ;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, int_shadow, guest_exit;
	logic [7:0] paddr, exit_code;
	logic [31:0] pwdata, prdata, seed, r, vm_control_block_wback;
	logic in_guest, system_mgmt_memory_mapped, exit_info_virt_nmi_feature;
	logic [7:0] evin;
	logic [3:0] evo;
	logic [32:0] rq[$];
	logic [7:0] eq[$];
	int cnt[4];
	int miscompares, checked;

	vnsg_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.phys_nmi(evin[0]), .ext_smi(evin[1]), .ext_smi_io(evin[2]), .int_smi(evin[3]),
		.int_shadow(int_shadow), .iret_ok(evin[4]), .vec_done(evin[5]), .exit_req(evin[6]),
		.smm_return(evin[7]), .nmi_taken(evo[0]), .smi_taken(evo[1]), .virt_nmi_feature_taken(evo[2]),
		.guest_exit(guest_exit), .exit_code(exit_code), .exit_info_virt_nmi_feature(exit_info_virt_nmi_feature), .vm_control_block_wback(vm_control_block_wback),
		.in_guest(in_guest), .system_mgmt_memory_mapped(system_mgmt_memory_mapped), .gp_fault(evo[3]));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task err(input string m);
		miscompares++;
		$display("[ERR] %0t %s", $time, m);
	endtask : err

	task cmp_rd(input logic [32:0] got, input logic [32:0] exp);
		checked++;
		if (got !== exp) err($sformatf("read %h expected %h", got, exp));
	endtask : cmp_rd

	task cmp_code(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) err($sformatf("exit code %h expected %h", got, exp));
	endtask : cmp_code

	task cmp_pin(input logic [34:0] exp);
		checked++;
		if ({in_guest, system_mgmt_memory_mapped, exit_info_virt_nmi_feature, vm_control_block_wback} !== exp) begin
			err($sformatf("pins %h expected %h", {in_guest, system_mgmt_memory_mapped, exit_info_virt_nmi_feature, vm_control_block_wback}, exp));
		end
	endtask : cmp_pin

	task results();
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n == 16) err("no pready");
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rd(input logic [7:0] a, input logic [32:0] e);
		rq.push_back(e);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd

	task idle(input int n);
		repeat (n) @(posedge pclk);
	endtask : idle

	task pulse(input int i);
		evin[i] <= 1'b1;
		@(posedge pclk);
		evin[i] <= 1'b0;
		@(posedge pclk);
	endtask : pulse

	task automatic wait_ev(input int i);
		int n;
		n = 0;
		while (cnt[i] == 0 && n < 60) begin
			@(posedge pclk);
			n++;
		end
		checked++;
		if (cnt[i] == 0) err("event pulse missing");
		else cnt[i]--;
	endtask : wait_ev

	task entry(input logic [7:0] code, input logic [31:0] cmd);
		eq.push_back(code);
		wr(`VNSG_ADDR_CMD, cmd);
		idle(3);
	endtask : entry

	// Collects read results and exit codes and matches them with the oldest notes; counts event pulses.
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
			if (rq.size() == 0) err("read without note");
			else cmp_rd({pslverr, prdata}, rq.pop_front());
		end
		if (guest_exit === 1'b1) begin
			if (eq.size() == 0) err("unexpected guest exit");
			else cmp_code(exit_code, eq.pop_front());
		end
		for (int i = 0; i < 4; i++) if (evo[i] === 1'b1) cnt[i]++;
	end

	initial begin
		repeat (20000) @(posedge pclk);
		err("timeout");
		results();
	end

	initial begin
		seed = 32'd81356;
		presetn = 1'b0;
		{psel, penable, pwrite, int_shadow} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		evin = 8'h00;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`VNSG_ADDR_STAT, 33'h0_0000_0100);
		rd(`VNSG_ADDR_CMD, 33'h0_0000_0000);
		rd(8'h20, 33'h1_0000_0000);
		r = xs();
		wr(`VNSG_ADDR_SMMCTL, r);
		rd(`VNSG_ADDR_SMMCTL, {1'b0, r});
		wr(`VNSG_ADDR_HWCFG, 32'h0000_0001);
		rd(`VNSG_ADDR_HWCFG, 33'h0_0000_0001);
		wr(`VNSG_ADDR_SMMCTL, ~r);
		wait_ev(3);
		rd(`VNSG_ADDR_SMMCTL, {1'b0, r});
		wr(`VNSG_ADDR_VM_CONTROL_BLOCK, 32'h0400_0000);
		wr(`VNSG_ADDR_CTRL, 32'h0000_0000);
		entry(`VNSG_EXIT_INVALID, 32'h0000_0001);
		rd(`VNSG_ADDR_STAT, 33'h0_0000_0100);
		wr(`VNSG_ADDR_VM_CONTROL_BLOCK, 32'h0000_0000);
		wr(`VNSG_ADDR_CTRL, 32'h0000_0005);
		entry(`VNSG_EXIT_NMI, 32'h0000_0001);
		pulse(0);
		idle(4);
		rd(`VNSG_ADDR_STAT, 33'h0_0000_0108);
		wr(`VNSG_ADDR_CMD, 32'h0000_0004);
		wait_ev(0);
		wr(`VNSG_ADDR_CMD, 32'h0000_0008);
		rd(`VNSG_ADDR_CTRL, 33'h0_0000_0004);
		wr(`VNSG_ADDR_CTRL, 32'h0000_0009);
		entry(`VNSG_EXIT_SMI, 32'h0000_0001);
		pulse(3);
		idle(4);
		rd(`VNSG_ADDR_STAT, 33'h0_0000_0100);
		pulse(3);
		idle(4);
		rd(`VNSG_ADDR_STAT, 33'h0_0000_0100);
		entry(`VNSG_EXIT_SMI, 32'h0000_0001);
		pulse(1);
		idle(4);
		rd(`VNSG_ADDR_STAT, 33'h0_0000_0110);
		wr(`VNSG_ADDR_CMD, 32'h0000_0004);
		wait_ev(1);
		rd(`VNSG_ADDR_STAT, 33'h0_0000_01A0);
		cmp_pin(35'h2_0000_0000);
		pulse(7);
		idle(3);
		rd(`VNSG_ADDR_STAT, 33'h0_0000_0100);
		wr(`VNSG_ADDR_CTRL, 32'h0000_0001);
		wr(`VNSG_ADDR_CMD, 32'h0000_0001);
		pulse(2);
		wait_ev(1);
		pulse(7);
		idle(3);
		rd(`VNSG_ADDR_STAT, 33'h0_0000_0140);
		cmp_pin(35'h4_0000_0000);
		eq.push_back(`VNSG_EXIT_OTHER);
		pulse(6);
		idle(3);
		wr(`VNSG_ADDR_VM_CONTROL_BLOCK, 32'h0400_0800);
		rd(`VNSG_ADDR_VM_CONTROL_BLOCK, 33'h0_0400_0800);
		wr(`VNSG_ADDR_CTRL, 32'h0000_0007);
		int_shadow <= 1'b1;
		wr(`VNSG_ADDR_CMD, 32'h0000_0003);
		idle(4);
		rd(`VNSG_ADDR_STAT, 33'h0_0000_0143);
		pulse(4);
		idle(4);
		rd(`VNSG_ADDR_STAT, 33'h0_0000_0141);
		int_shadow <= 1'b0;
		wait_ev(2);
		rd(`VNSG_ADDR_STAT, 33'h0_0000_0146);
		eq.push_back(`VNSG_EXIT_OTHER);
		pulse(6);
		idle(4);
		rd(`VNSG_ADDR_WBACK, 33'h0_0400_0000);
		rd(`VNSG_ADDR_EXIT, 33'h0_0000_0103);
		idle(4);
		cmp_pin(35'h1_0400_0000);
		if (rq.size() != 0 || eq.size() != 0 || cnt[0] + cnt[1] + cnt[2] + cnt[3] != 0) begin
			err("notes or pulses left over");
		end
		results();
	end
endmodule : vnsg_top_tb
`default_nettype wire
